// *** cdrbh_fe_model.sv ***
module cdrbh_fe_model
   import cdrbh_pkg::*;
(
   input  wire logic clk_sys,
   output logic      q_bit,
   output logic      q_sync,
   output logic      sub_bit_strobe
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      q_bit = 1'b0;
      q_sync = 1'b0;
      sub_bit_strobe = 1'b0;
   end

   // ==========================================================
   // one q frame
   // rep strobes per bit; bad sends the crc without inversion
   task automatic send_q(input logic [79:0] pay, input int rep,
                         input logic bad);
      logic [15:0] crc;
      logic [95:0] fr;
      crc = CRC_INIT;
      for (int i = 79; i >= 0; i--) begin
         crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ pay[i]) ? CRC_POLY : 16'h0);
      end
      fr = {pay, bad ? crc : ~crc};
      @(posedge clk_sys);
      q_sync <= 1'b1;
      @(posedge clk_sys);
      q_sync <= 1'b0;
      for (int b = 95; b >= 0; b--) begin
         for (int r = 0; r < rep; r++) begin
            @(posedge clk_sys);
            q_bit <= fr[b];
            sub_bit_strobe <= 1'b1;
            @(posedge clk_sys);
            sub_bit_strobe <= 1'b0;
         end
      end
      // idle line shows the inverse, never a stale bit
      q_bit <= ~fr[0];
   endtask : send_q
endmodule : cdrbh_fe_model

// *** cdrbh_pkg.sv ***
package cdrbh_pkg;
   // ==========================================================
   // register offsets
   localparam logic [15:0] A_Q_ZERO_BYTE  = 16'hF084;
   localparam logic [15:0] A_RPTCNT = 16'hF08F;
   localparam logic [15:0] A_HMODE  = 16'hF092;
   localparam logic [15:0] A_HMIN   = 16'hF093;
   localparam logic [15:0] A_TDB_LO = 16'hF096;
   localparam logic [15:0] A_TDB_HI = 16'hF097;
   localparam logic [15:0] A_HSEC   = 16'hF09A;
   localparam logic [15:0] A_HFRM   = 16'hF09B;
   localparam logic [15:0] A_WTCTL  = 16'hF0C1;
   localparam logic [15:0] A_HOSTM  = 16'hF0FD;
   localparam logic [15:0] A_OWNCTL = 16'hF0E0;
   localparam logic [15:0] A_SMIN   = 16'hF0E1;
   localparam logic [15:0] A_SSEC   = 16'hF0E2;
   localparam logic [15:0] A_SFRM   = 16'hF0E3;
   localparam logic [15:0] A_STOPC  = 16'hF0E4;
   localparam logic [15:0] A_STAT   = 16'hF0E5;
   // q bytes: zero,track,index,mode,amin,asec,afrm,rmin,rsec,rfrm
   localparam logic [9:0][15:0] Q_ADDR = {
      16'hF084, 16'hF094, 16'hF095, 16'hF0A9, 16'hF0AA,
      16'hF0AB, 16'hF0B1, 16'hF0B2, 16'hF0CF, 16'hF0FA};
   // ==========================================================
   // field positions and reset values
   localparam int WT_AUTO = 0;
   localparam int WT_HDIR = 1;
   localparam int WT_BSB  = 2;
   localparam int WT_OVR  = 3;
   localparam int WT_ENCODER_BYTE_SWAP = 4;
   localparam int HM_FAST = 5;
   localparam int OC_TDEN = 0;
   localparam int OC_AUD  = 1;
   localparam logic [4:0]  WT_RST     = 5'h00;
   localparam logic [6:0]  HM_RST     = 7'h00;
   localparam logic [1:0]  BURST_SLOW = 2'h3;
   localparam logic [1:0]  BURST_FAST = 2'h2;
   localparam logic [15:0] CRC_POLY   = 16'h1021;
   localparam logic [15:0] CRC_INIT   = 16'h0000;
   localparam logic [15:0] CRC_INV    = 16'hFFFF;
   localparam logic [1:0]  QSAMP_LAST = 2'h3;
   localparam logic [6:0]  Q_PAY_BITS = 7'h50;
   localparam logic [6:0]  Q_LAST_BIT = 7'h5F;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } cdrbh_bus_t;
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] mins;
      logic [7:0] secs;
      logic [7:0] frm;
   } cdrbh_hdr_t;
endpackage : cdrbh_pkg

// *** cdrbh_top.sv ***
// Function
// R1: 11-bit descriptor frame address, low byte plus three bits high, read/write.
// R2: enabled and frame count equals address: frame counter holds until repeat zero.
// R3: auto-store bit starts storing when header/Q address matches start MINUTE_SECOND_FRAME_ADDRESS.
// R4: header or Q error on compared address suppresses auto-store start.
// R5: once started, storing runs until stop count reaches zero, then stops.
// R6: host direction low selects microcontroller path, high selects DMA path.
// R7: firmware should keep host direction high for controllers with own command path.
// R8: audio mode swaps sample bytes by default; swap-disable bit stores as data.
// R9: quarter-rate bit samples sub-code at a quarter of data rate.
// R10: encoder swap bit exchanges high and low bytes toward encoder.
// R11: host-mode register outputs drive DRAM controls directly, immediately.
// R12: host-mode bit 0 selects byte access at 0, page access at 1.
// R13: host-mode bit 1 selects buffer read at 0, buffer write at 1.
// R14: two host-mode bits choose A or B sets for offset start/end.
// R15: offset address bit: 0 uses only A registers, 1 uses A and B.
// R16: burst speed bit: three cycles per burst read at 0, two at 1.
// R17: host-mode bit 6 selects one of two DRAM timing profiles.
// R18: four read-only header bytes, valid while header-ready flag set.
// R19: audio mode takes compared MINUTE_SECOND_FRAME_ADDRESS address from Q-channel data.
// R20: ten read-only Q-channel bytes: zero, track, index, mode, abs, rel MINUTE_SECOND_FRAME_ADDRESS.
// R21: repeat count is loadable readable eight-bit down counter.
// R22: twelve Q bytes per sector, last two CRC, validity after final bit.
// R23: register write lands on next edge and reads back afterward.
//
// Design decision made here: the address-and-strobe port.
module cdrbh_top
   import cdrbh_pkg::*;
#(
   parameter int FRAME_W = 11
) (
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire cdrbh_bus_t  bus,
   input  wire logic        frame_end,
   input  wire logic [15:0] fe_word,
   input  wire logic        fe_word_valid,
   input  wire cdrbh_hdr_t  hdr_in,
   input  wire logic        hdr_load,
   input  wire logic        hdr_error,
   input  wire logic        hdr_clear,
   input  wire logic        sub_bit_strobe,
   input  wire logic        q_bit,
   input  wire logic        q_sync,
   input  wire logic [15:0] enc_word_in,
   output logic [7:0]       rd_data,
   output logic [10:0]      frame_count,
   output logic             descriptor_hold,
   output logic             store_active,
   output logic [15:0]      store_word,
   output logic             store_word_valid,
   output logic [15:0]      enc_word,
   output logic             host_direction_select,
   output logic             subcode_sample,
   output logic             q_frame_ready,
   output logic             byte_or_page_access,
   output logic             buffer_write_select,
   output logic             offset_start_set_select,
   output logic             offset_end_set_select,
   output logic             offset_use_both_sets,
   output logic [1:0]       burst_cycles,
   output logic             controller_timing_select
);
   // ==========================================================
   // elaboration check
   if (FRAME_W != 11) begin : g_chk
      $error("frame address width must be 11");
   end

   // ==========================================================
   // state
   typedef struct packed {
      logic [4:0]  wt;
      logic [6:0]  hm;
      logic [1:0]  burst;
      logic [10:0] descriptor_address_low;
      logic [7:0]  rpt;
      logic [1:0]  oc;
      logic [7:0]  smin;
      logic [7:0]  ssec;
      logic [7:0]  sfrm;
      logic [7:0]  stopc;
      logic        storing;
      cdrbh_hdr_t  hdr;
      logic        hdr_rdy;
      logic [79:0] qreg;
      logic [95:0] qsh;
      logic [6:0]  qcnt;
      logic [15:0] crc;
      logic        qbad;
      logic        qrdy;
      logic [1:0]  sdiv;
      logic        samp;
      logic [10:0] fcnt;
      logic        hold;
      logic [15:0] sword;
      logic        svalid;
      logic [15:0] eword;
      logic [7:0]  rdat;
   } cdrbh_st_t;

   cdrbh_st_t st_r;
   cdrbh_st_t st_nxt;

   always_comb begin
      logic        samp;
      logic        hold;
      logic        fb;
      logic [95:0] qfull;
      logic        evt;
      logic        err;
      logic [23:0] minute_second_frame_address;
      logic [7:0]  rv;
      st_nxt = st_r;
      samp   = 1'b0;
      hold   = 1'b0;
      fb     = 1'b0;
      qfull  = {st_r.qsh[94:0], q_bit};
      evt    = 1'b0;
      err    = 1'b0;
      minute_second_frame_address    = {hdr_in.mins, hdr_in.secs, hdr_in.frm};
      rv     = 8'h00;

      // ==========================================================
      // register writes
      if (bus.wr) begin
         unique case (bus.addr)
            // R1 address write
            A_TDB_LO: st_nxt.descriptor_address_low[7:0]  = bus.wdata;
            A_TDB_HI: st_nxt.descriptor_address_low[10:8] = bus.wdata[2:0];
            // R21 count reload
            A_RPTCNT: st_nxt.rpt  = bus.wdata;
            A_WTCTL:  st_nxt.wt   = bus.wdata[4:0];
            A_OWNCTL: st_nxt.oc   = bus.wdata[1:0];
            A_SMIN:   st_nxt.smin = bus.wdata;
            A_SSEC:   st_nxt.ssec = bus.wdata;
            A_SFRM:   st_nxt.sfrm = bus.wdata;
            A_STOPC:  st_nxt.stopc = bus.wdata;
            A_HOSTM: begin
               // R11 direct control
               st_nxt.hm = bus.wdata[6:0];
               // R16 burst length
               st_nxt.burst = bus.wdata[HM_FAST] ? BURST_FAST
                                                 : BURST_SLOW;
            end
            default: ;
         endcase
      end

      // ==========================================================
      // R9 sub-code sampling rate
      if (sub_bit_strobe) begin
         if (st_r.wt[WT_OVR]) begin
            st_nxt.sdiv = st_r.sdiv + 2'h1;
            samp        = (st_r.sdiv == QSAMP_LAST);
         end else begin
            samp = 1'b1;
         end
      end
      st_nxt.samp = samp;

      // ==========================================================
      // R22 q assembly and crc
      st_nxt.qrdy = 1'b0;
      if (q_sync) begin
         st_nxt.qcnt = 7'h00;
         st_nxt.crc  = CRC_INIT;
         st_nxt.sdiv = 2'h0;
      end else if (samp) begin
         st_nxt.qsh = qfull;
         if (st_r.qcnt < Q_PAY_BITS) begin
            fb = st_r.crc[15] ^ q_bit;
            st_nxt.crc = {st_r.crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
         end
         if (st_r.qcnt == Q_LAST_BIT) begin
            // R20 q registers load
            st_nxt.qreg = qfull[95:16];
            st_nxt.qbad = ((st_r.crc ^ CRC_INV) != qfull[15:0]);
            st_nxt.qrdy = 1'b1;
            st_nxt.qcnt = 7'h00;
            st_nxt.crc  = CRC_INIT;
         end else begin
            st_nxt.qcnt = st_r.qcnt + 7'h01;
         end
      end

      // ==========================================================
      // R18 header capture, set wins over clear
      if (hdr_load) begin
         st_nxt.hdr     = hdr_in;
         st_nxt.hdr_rdy = 1'b1;
      end else if (hdr_clear) begin
         st_nxt.hdr_rdy = 1'b0;
      end

      // ==========================================================
      // R19 address source per mode
      if (st_r.oc[OC_AUD]) begin
         evt = st_nxt.qrdy;
         err = st_nxt.qbad;
         minute_second_frame_address = qfull[63:40];
      end else begin
         evt = hdr_load;
         err = hdr_error;
      end

      // ==========================================================
      // R5 stop on count zero
      if (st_r.storing) begin
         if (st_r.stopc == 8'h00) begin
            st_nxt.storing = 1'b0;
         end else if (frame_end && !(bus.wr && bus.addr == A_STOPC)) begin
            st_nxt.stopc = st_r.stopc - 8'h01;
         end
      // R3 auto-store start, R4 error suppress
      end else if (st_r.wt[WT_AUTO] && evt && !err &&
                   minute_second_frame_address == {st_r.smin, st_r.ssec, st_r.sfrm}) begin
         st_nxt.storing = 1'b1;
      end

      // ==========================================================
      // R2 descriptor frame hold
      hold = st_r.oc[OC_TDEN] && (st_r.fcnt == st_r.descriptor_address_low) &&
             (st_r.rpt != 8'h00);
      if (frame_end) begin
         if (hold) begin
            if (!(bus.wr && bus.addr == A_RPTCNT)) begin
               st_nxt.rpt = st_r.rpt - 8'h01;
            end
         end else begin
            st_nxt.fcnt = st_r.fcnt + 11'h001;
         end
      end
      st_nxt.hold = st_nxt.oc[OC_TDEN] && (st_nxt.fcnt == st_nxt.descriptor_address_low) &&
                    (st_nxt.rpt != 8'h00);

      // ==========================================================
      // R8 audio byte swap
      st_nxt.svalid = fe_word_valid && st_r.storing;
      if (fe_word_valid) begin
         st_nxt.sword = (st_r.oc[OC_AUD] && !st_r.wt[WT_BSB]) ?
                        {fe_word[7:0], fe_word[15:8]} : fe_word;
      end
      // R10 encoder swap
      st_nxt.eword = st_r.wt[WT_ENCODER_BYTE_SWAP] ?
                     {enc_word_in[7:0], enc_word_in[15:8]} : enc_word_in;

      // ==========================================================
      // R23 read back, data one cycle later
      if (bus.rd) begin
         unique case (bus.addr)
            A_TDB_LO: rv = st_r.descriptor_address_low[7:0];
            A_TDB_HI: rv = {5'h00, st_r.descriptor_address_low[10:8]};
            A_RPTCNT: rv = st_r.rpt;
            A_WTCTL:  rv = {3'h0, st_r.wt};
            A_HOSTM:  rv = {1'b1, st_r.hm};
            A_OWNCTL: rv = {6'h00, st_r.oc};
            A_SMIN:   rv = st_r.smin;
            A_SSEC:   rv = st_r.ssec;
            A_SFRM:   rv = st_r.sfrm;
            A_STOPC:  rv = st_r.stopc;
            A_STAT:   rv = {4'h0, st_r.qbad, st_r.hold, st_r.hdr_rdy,
                            st_r.storing};
            A_HMODE:  rv = st_r.hdr.mode;
            A_HMIN:   rv = st_r.hdr.mins;
            A_HSEC:   rv = st_r.hdr.secs;
            A_HFRM:   rv = st_r.hdr.frm;
            default: begin
               for (int i = 0; i < 10; i++) begin
                  if (bus.addr == Q_ADDR[i]) begin
                     rv = st_r.qreg[8*i +: 8];
                  end
               end
            end
         endcase
      end
      st_nxt.rdat = rv;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_r       <= '0;
         st_r.wt    <= WT_RST;
         st_r.hm    <= HM_RST;
         st_r.burst <= BURST_SLOW;
         st_r.crc   <= CRC_INIT;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign rd_data          = st_r.rdat;
   assign frame_count      = st_r.fcnt;
   assign descriptor_hold  = st_r.hold;
   assign store_active     = st_r.storing;
   assign store_word       = st_r.sword;
   assign store_word_valid = st_r.svalid;
   assign enc_word         = st_r.eword;
   // R6 host path select
   assign host_direction_select = st_r.wt[WT_HDIR];
   assign subcode_sample        = st_r.samp;
   assign q_frame_ready         = st_r.qrdy;
   // R12 byte or page
   assign byte_or_page_access     = st_r.hm[0];
   // R13 buffer direction
   assign buffer_write_select     = st_r.hm[1];
   // R14 offset set choice
   assign offset_start_set_select = st_r.hm[2];
   assign offset_end_set_select   = st_r.hm[3];
   // R15 both sets
   assign offset_use_both_sets    = st_r.hm[4];
   assign burst_cycles            = st_r.burst;
   // R17 timing profile
   assign controller_timing_select = st_r.hm[6];

   // ==========================================================
   // checks
   property p_tdb_hi;
      @(posedge clk_sys) disable iff (!arst_n)
      bus.wr && bus.addr == A_TDB_HI |=> st_r.descriptor_address_low[10:8] == $past(bus.wdata[2:0]);
   endproperty
   a_tdb_hi: assert property (p_tdb_hi) else $error("tdb high"); // R1

   property p_hold;
      @(posedge clk_sys) disable iff (!arst_n)
      descriptor_hold && frame_end |=> $stable(frame_count);
   endproperty
   a_hold: assert property (p_hold) else $error("frame moved"); // R2

   property p_start;
      @(posedge clk_sys) disable iff (!arst_n)
      $rose(store_active) |-> $past(st_r.wt[WT_AUTO]);
   endproperty
   a_start: assert property (p_start) else $error("bad start"); // R3

   property p_err;
      @(posedge clk_sys) disable iff (!arst_n)
      !store_active && hdr_load && hdr_error && !st_r.oc[OC_AUD]
      |=> !store_active;
   endproperty
   a_err: assert property (p_err) else $error("start on error"); // R4

   property p_stop;
      @(posedge clk_sys) disable iff (!arst_n)
      store_active && st_r.stopc == 8'h00 |=> !store_active;
   endproperty
   a_stop: assert property (p_stop) else $error("no stop"); // R5

   property p_swap;
      @(posedge clk_sys) disable iff (!arst_n)
      fe_word_valid && st_r.oc[OC_AUD] && !st_r.wt[WT_BSB]
      |=> store_word == {$past(fe_word[7:0]), $past(fe_word[15:8])};
   endproperty
   a_swap: assert property (p_swap) else $error("audio swap"); // R8

   property p_enc;
      @(posedge clk_sys) disable iff (!arst_n)
      st_r.wt[WT_ENCODER_BYTE_SWAP] ##1 1'b1
      |-> enc_word == {$past(enc_word_in[7:0]), $past(enc_word_in[15:8])};
   endproperty
   a_enc: assert property (p_enc) else $error("enc swap"); // R10

   property p_burst;
      @(posedge clk_sys) disable iff (!arst_n)
      bus.wr && bus.addr == A_HOSTM
      |=> burst_cycles == ($past(bus.wdata[HM_FAST]) ? 2'h2 : 2'h3);
   endproperty
   a_burst: assert property (p_burst) else $error("burst len"); // R16

   property p_rdback;
      @(posedge clk_sys) disable iff (!arst_n)
      bus.wr && bus.addr == A_SMIN ##1 bus.rd && bus.addr == A_SMIN
      |=> rd_data == $past(bus.wdata, 2);
   endproperty
   a_rdback: assert property (p_rdback) else $error("readback"); // R23
endmodule : cdrbh_top

// *** test_cdrbh_top.sv ***
module test_cdrbh_top import cdrbh_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_sys = 1'b0;
   logic        arst_n = 1'b0;
   cdrbh_bus_t  bus = '0;
   logic        frame_end = 1'b0;
   logic [15:0] fe_word = 16'h0000;
   logic        fe_word_valid = 1'b0;
   cdrbh_hdr_t  hdr_in = '0;
   logic        hdr_load = 1'b0;
   logic        hdr_error = 1'b0;
   logic        hdr_clear = 1'b0;
   logic        sub_bit_strobe, q_bit, q_sync;
   logic [15:0] enc_word_in = 16'h0000;
   logic [7:0]  rd_data;
   logic [10:0] frame_count;
   logic        descriptor_hold, store_active, store_word_valid;
   logic [15:0] store_word, enc_word;
   logic        host_direction_select, subcode_sample, q_frame_ready;
   logic        byte_or_page_access, buffer_write_select;
   logic        offset_start_set_select, offset_end_set_select;
   logic        offset_use_both_sets, controller_timing_select;
   logic [1:0]  burst_cycles;
   int          err_count = 0;
   int          compares = 0;
   int          seed = 30;
   int          qrdy_cnt = 0;
   int          samp_cnt = 0;
   logic [7:0]  qb [10];

   cdrbh_top i_dut (.clk_sys, .arst_n, .bus, .frame_end, .fe_word,
      .fe_word_valid, .hdr_in, .hdr_load, .hdr_error, .hdr_clear,
      .sub_bit_strobe, .q_bit, .q_sync, .enc_word_in, .rd_data,
      .frame_count, .descriptor_hold, .store_active, .store_word,
      .store_word_valid, .enc_word, .host_direction_select,
      .subcode_sample, .q_frame_ready, .byte_or_page_access,
      .buffer_write_select, .offset_start_set_select,
      .offset_end_set_select, .offset_use_both_sets, .burst_cycles,
      .controller_timing_select);

   cdrbh_fe_model i_fe (.clk_sys, .q_bit, .q_sync, .sub_bit_strobe);

   always #5 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      if (q_frame_ready === 1'b1) begin
         qrdy_cnt++;
      end
      if (subcode_sample === 1'b1) begin
         samp_cnt++;
      end
   end

   // ==========================================================
   // helpers
   function automatic logic [15:0] swap16(input logic [15:0] w);
      return {w[7:0], w[15:8]};
   endfunction : swap16

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic finish_test();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus.wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1;
      check({8'h00, rd_data}, {8'h00, e});
   endtask : rd

   task automatic fend(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         frame_end <= 1'b1;
         @(posedge clk_sys);
         frame_end <= 1'b0;
      end
      @(posedge clk_sys);
      #1;
   endtask : fend

   task automatic feed(input logic [15:0] w, input logic [15:0] e);
      @(posedge clk_sys);
      fe_word <= w;
      fe_word_valid <= 1'b1;
      @(posedge clk_sys);
      fe_word_valid <= 1'b0;
      #1;
      check({15'h0, store_word_valid}, 16'h0001);
      check(store_word, e);
   endtask : feed

   task automatic hdr(input cdrbh_hdr_t h, input logic er);
      @(posedge clk_sys);
      hdr_in <= h;
      hdr_error <= er;
      hdr_load <= 1'b1;
      @(posedge clk_sys);
      hdr_load <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : hdr

   // ==========================================================
   // watchdog
   initial begin
      #200000;
      err_count++;
      finish_test();
   end

   // ==========================================================
   // main sequence
   initial begin
      logic [7:0]  v;
      logic [15:0] hm;
      logic [15:0] w;
      logic [79:0] pay;
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      #1;
      check({14'h0, burst_cycles}, 16'h0003);
      check({15'h0, host_direction_select}, 16'h0000);
      rd(A_HOSTM, 8'h80);
      rd(A_WTCTL, 8'h00);
      rd(16'hF000, 8'h00);
      for (int i = 0; i < 10; i++) begin
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'h7F : 8'($random(seed));
         wr(A_HOSTM, v);
         hm = {10'h0, controller_timing_select, offset_use_both_sets,
               offset_end_set_select, offset_start_set_select,
               buffer_write_select, byte_or_page_access};
         check(hm, {10'h0, v[6], v[4:0]});
         check({14'h0, burst_cycles}, v[5] ? 16'h2 : 16'h3);
         rd(A_HOSTM, {1'b1, v[6:0]});
      end
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         v[4] = i[0];
         v[1] = i[1];
         wr(A_WTCTL, {3'h0, v[4:1], 1'b0});
         check({15'h0, host_direction_select}, {15'h0, v[1]});
         rd(A_WTCTL, {3'h0, v[4:1], 1'b0});
         @(posedge clk_sys);
         enc_word_in <= 16'($random(seed));
         @(posedge clk_sys);
         #1;
         check(enc_word, v[4] ? swap16(enc_word_in) : enc_word_in);
      end
      wr(A_TDB_LO, 8'hFF);
      wr(A_TDB_HI, 8'hFF);
      rd(A_TDB_LO, 8'hFF);
      rd(A_TDB_HI, 8'h07);
      wr(A_TDB_LO, 8'h05);
      wr(A_TDB_HI, 8'h00);
      wr(A_RPTCNT, 8'h02);
      wr(A_OWNCTL, 8'h01);
      fend(5);
      check({5'h0, frame_count}, 16'h0005);
      check({15'h0, descriptor_hold}, 16'h0001);
      fend(1);
      check({5'h0, frame_count}, 16'h0005);
      rd(A_RPTCNT, 8'h01);
      fend(1);
      check({15'h0, descriptor_hold}, 16'h0000);
      fend(1);
      check({5'h0, frame_count}, 16'h0006);
      wr(A_OWNCTL, 8'h00);
      v = 8'($random(seed));
      @(posedge clk_sys);
      bus <= '{addr: A_SMIN, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus <= '{addr: A_SMIN, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1;
      check({8'h00, rd_data}, {8'h00, v});
      wr(A_SMIN, 8'h12);
      wr(A_SSEC, 8'h34);
      wr(A_SFRM, 8'h56);
      wr(A_STOPC, 8'h02);
      wr(A_WTCTL, 8'h03);
      hdr('{8'h01, 8'h12, 8'h34, 8'h56}, 1'b1);
      check({15'h0, store_active}, 16'h0000);
      hdr('{8'h01, 8'h13, 8'h34, 8'h56}, 1'b0);
      check({15'h0, store_active}, 16'h0000);
      rd(A_HMIN, 8'h13);
      hdr('{8'h01, 8'h12, 8'h34, 8'h56}, 1'b0);
      check({15'h0, store_active}, 16'h0001);
      rd(A_HMODE, 8'h01);
      rd(A_HSEC, 8'h34);
      rd(A_HFRM, 8'h56);
      rd(A_STAT, 8'h03);
      w = 16'($random(seed));
      feed(w, w);
      fend(1);
      check({15'h0, store_active}, 16'h0001);
      fend(1);
      check({15'h0, store_active}, 16'h0000);
      @(posedge clk_sys);
      hdr_clear <= 1'b1;
      @(posedge clk_sys);
      hdr_clear <= 1'b0;
      rd(A_STAT, 8'h00);
      for (int i = 0; i < 10; i++) begin
         qb[i] = 8'($random(seed));
         pay = {pay[71:0], qb[i]};
      end
      wr(A_OWNCTL, 8'h02);
      wr(A_SMIN, qb[4]);
      wr(A_SSEC, qb[5]);
      wr(A_SFRM, qb[6]);
      wr(A_STOPC, 8'h01);
      wr(A_WTCTL, 8'h03);
      i_fe.send_q(pay, 1, 1'b0);
      repeat (3) @(posedge clk_sys);
      #1;
      check(16'(qrdy_cnt), 16'h0001);
      check(16'(samp_cnt), 16'h0060);
      check({15'h0, store_active}, 16'h0001);
      for (int i = 0; i < 10; i++) begin
         rd(Q_ADDR[9 - i], qb[i]);
      end
      rd(A_STAT, 8'h01);
      w = 16'($random(seed));
      feed(w, swap16(w));
      wr(A_WTCTL, 8'h07);
      feed(~w, ~w);
      fend(1);
      check({15'h0, store_active}, 16'h0000);
      for (int i = 0; i < 10; i++) begin
         qb[i] = (i > 3 && i < 7) ? qb[i] : ~qb[i];
         pay = {pay[71:0], qb[i]};
      end
      wr(A_STOPC, 8'h01);
      wr(A_WTCTL, 8'h0B);
      i_fe.send_q(pay, 4, 1'b1);
      repeat (3) @(posedge clk_sys);
      #1;
      check(16'(qrdy_cnt), 16'h0002);
      check(16'(samp_cnt), 16'h00C0);
      check({15'h0, store_active}, 16'h0000);
      for (int i = 0; i < 10; i++) begin
         rd(Q_ADDR[9 - i], qb[i]);
      end
      rd(A_STAT, 8'h08);
      finish_test();
   end
endmodule : test_cdrbh_top
